// [src/dmid_pkg.sv]
package dmid_pkg;
   localparam int DMID_INSTR_W = 14;
   localparam int DMID_DATA_W = 8;
   localparam int DMID_ADDR_W = 7;
   // opcode fields
   localparam logic [5:0] DMID_COPY_OP = 6'h08;
   localparam int DMID_COPY_OP_LSB = 8;
   localparam int DMID_DEST_BIT = 7;
   localparam logic [6:0] DMID_STORE_OP = 7'h01;
   localparam int DMID_STORE_OP_LSB = 7;
   localparam logic [13:0] DMID_CFG_LOAD_CODE = 14'h0062;
   localparam logic [6:0] DMID_IDLE_HI = 7'h00;
   localparam int DMID_IDLE_HI_LSB = 7;
   localparam logic [4:0] DMID_IDLE_LO = 5'h00;
   localparam int DMID_IDLE_LO_MSB = 4;
   // reset values and the file address of the configuration register
   localparam logic [7:0] DMID_ACC_RESET = 8'h00;
   localparam logic DMID_ZERO_RESET = 1'b0;
   localparam logic [7:0] DMID_CFG_RESET = 8'hff;
   localparam logic [6:0] DMID_CFG_ADDR = 7'h01;
endpackage

// [src/dmid_decoder.sv]
`timescale 1ns/1ps
module dmid_decoder
(
   input wire logic [dmid_pkg::DMID_INSTR_W-1:0] instr,
   output logic is_copy,
   output logic copy_to_file,
   output logic is_store,
   output logic is_cfg_load,
   output logic is_idle,
   output logic [dmid_pkg::DMID_ADDR_W-1:0] file_addr
);
   import dmid_pkg::*;
   always_comb begin
      is_copy = (instr[DMID_INSTR_W-1:DMID_COPY_OP_LSB] == DMID_COPY_OP); // [RL1]
      copy_to_file = instr[DMID_DEST_BIT]; // [RL1]
      is_store = (instr[DMID_INSTR_W-1:DMID_STORE_OP_LSB] == DMID_STORE_OP); // [RL3]
      is_cfg_load = (instr == DMID_CFG_LOAD_CODE); // [RL4]
      // the two middle bits are don't-care
      is_idle = (instr[DMID_INSTR_W-1:DMID_IDLE_HI_LSB] == DMID_IDLE_HI)
         && (instr[DMID_IDLE_LO_MSB:0] == DMID_IDLE_LO); // [RL6]
      file_addr = instr[DMID_ADDR_W-1:0];
   end
endmodule

// [src/dmid_core.sv]
`timescale 1ns/1ps
// Behaviour
// RL1: copy file to accumulator or back to itself
// RL2: copy sets zero flag from moved value
// RL3: store accumulator to file, flags untouched
// RL4: fixed code loads accumulator into config register
// RL5: config register also an ordinary file register
// RL6: idle changes nothing; all single-cycle
module dmid_core
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic instr_valid,
   input wire logic [dmid_pkg::DMID_INSTR_W-1:0] instr,
   input wire logic [dmid_pkg::DMID_DATA_W-1:0] file_rdata,
   output logic [dmid_pkg::DMID_ADDR_W-1:0] file_addr,
   output logic file_we,
   output logic [dmid_pkg::DMID_DATA_W-1:0] file_wdata,
   output logic [dmid_pkg::DMID_DATA_W-1:0] acc_out,
   output logic zero_flag,
   output logic [dmid_pkg::DMID_DATA_W-1:0] cfg_out,
   output logic instr_handled
);
   import dmid_pkg::*;

   typedef struct packed {
      logic [DMID_DATA_W-1:0] acc;
      logic zero;
      logic [DMID_DATA_W-1:0] cfg;
   } dmid_state_type;

   dmid_state_type state_reg;
   dmid_state_type state_next;

   logic is_copy;
   logic copy_to_file;
   logic is_store;
   logic is_cfg_load;
   logic is_idle;
   logic [DMID_ADDR_W-1:0] addr;
   logic hits_cfg;
   logic [DMID_DATA_W-1:0] read_value;

   dmid_decoder u_decoder (
      .instr(instr),
      .is_copy(is_copy),
      .copy_to_file(copy_to_file),
      .is_store(is_store),
      .is_cfg_load(is_cfg_load),
      .is_idle(is_idle),
      .file_addr(addr)
   );

   // config register answers its file address instead of the outside file
   assign hits_cfg = (addr == DMID_CFG_ADDR); // [RL5]
   assign read_value = hits_cfg ? state_reg.cfg : file_rdata; // [RL5]

   assign file_addr = addr;
   // one action a cycle; copy wins should encodings ever overlap
   typedef enum logic [2:0] {
      DMID_OP_NONE = 3'b000,
      DMID_OP_COPY = 3'b001,
      DMID_OP_STORE = 3'b011,
      DMID_OP_CFG = 3'b010,
      DMID_OP_IDLE = 3'b110
   } dmid_op_type;

   dmid_op_type op;

   always_comb begin
      op = DMID_OP_NONE;
      if (instr_valid) begin
         if (is_copy) begin
            op = DMID_OP_COPY; // [RL1]
         end else if (is_store) begin
            op = DMID_OP_STORE; // [RL3]
         end else if (is_cfg_load) begin
            op = DMID_OP_CFG; // [RL4]
         end else if (is_idle) begin
            op = DMID_OP_IDLE; // [RL6]
         end
      end
   end

   // copy onto itself rewrites the same value, so no outside write is needed
   assign file_we = (op == DMID_OP_STORE) && !hits_cfg; // [RL3]
   assign file_wdata = state_reg.acc;
   assign acc_out = state_reg.acc;
   assign zero_flag = state_reg.zero;
   assign cfg_out = state_reg.cfg;
   // other opcodes belong to other decoders; low means not ours
   assign instr_handled = (op != DMID_OP_NONE); // [RL6]

   always_comb begin
      state_next = state_reg;
      unique case (op)
         DMID_OP_COPY: begin
            if (!copy_to_file) begin
               state_next.acc = read_value; // [RL1]
            end
            state_next.zero = (read_value == '0); // [RL2]
         end
         DMID_OP_STORE: begin
            if (hits_cfg) begin
               state_next.cfg = state_reg.acc; // [RL5]
            end
         end
         DMID_OP_CFG: begin
            state_next.cfg = state_reg.acc; // [RL4]
         end
         DMID_OP_IDLE: begin
            state_next = state_reg; // [RL6]
         end
         DMID_OP_NONE: begin
            state_next = state_reg;
         end
      endcase
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_reg.acc <= DMID_ACC_RESET;
         state_reg.zero <= DMID_ZERO_RESET;
         state_reg.cfg <= DMID_CFG_RESET;
      end else begin
         state_reg <= state_next;
      end
   end

   default clocking dmid_cb @(posedge clk);
   endclocking
   default disable iff (!arst_n);

   sequence copy_to_acc_s;
      instr_valid && is_copy && !copy_to_file;
   endsequence

   sequence copy_to_file_s;
      instr_valid && is_copy && copy_to_file;
   endsequence

   sequence copy_any_s;
      instr_valid && is_copy;
   endsequence

   sequence store_s;
      instr_valid && is_store;
   endsequence

   sequence cfg_load_s;
      instr_valid && is_cfg_load;
   endsequence

   sequence idle_s;
      instr_valid && is_idle;
   endsequence

   // words that belong to the other decoders
   sequence foreign_s;
      instr_valid && !is_copy && !is_store && !is_cfg_load && !is_idle;
   endsequence

   sequence quiet_s;
      !instr_valid;
   endsequence

   a_decode_exclusive: assert property ($onehot0({is_copy, is_store, is_cfg_load, is_idle})) // [RL6]
      else $error("more than one opcode decoded");
   a_addr_follows: assert property (file_addr == instr[DMID_ADDR_W-1:0]) // [RL1]
      else $error("file address not taken from the word");
   a_wdata_is_acc: assert property (file_wdata == acc_out) // [RL3]
      else $error("write data is not the accumulator");
   a_write_only_store: assert property (file_we |-> instr_valid && is_store && !hits_cfg) // [RL3]
      else $error("file written outside a store");

   a_copy_loads_acc: assert property (copy_to_acc_s |=> acc_out == $past(read_value)) // [RL1]
      else $error("copy did not load accumulator");
   a_copy_self_keeps: assert property (copy_to_file_s // [RL1]
      |=> $stable(acc_out) && $stable(cfg_out))
      else $error("copy to file altered accumulator or config");
   a_copy_sets_zero: assert property (copy_any_s // [RL2]
      |=> zero_flag == ($past(read_value) == 8'h00))
      else $error("zero flag wrong after copy");
   a_copy_no_write: assert property (copy_any_s |-> !file_we) // [RL1]
      else $error("copy wrote the file");
   a_copy_acc_cfg_kept: assert property (copy_to_acc_s |=> $stable(cfg_out)) // [RL1]
      else $error("copy to accumulator altered config");
   // reads at the config address must not come from the outside file
   a_copy_cfg_read: assert property ((copy_any_s and hits_cfg) // [RL5]
      |=> zero_flag == ($past(cfg_out) == 8'h00))
      else $error("copy from config address read the wrong source");

   a_store_flags_kept: assert property (store_s |=> $stable(zero_flag) && $stable(acc_out)) // [RL3]
      else $error("store altered flags or accumulator");
   a_store_write_data: assert property ((store_s and !hits_cfg) |-> file_we && file_wdata == acc_out) // [RL3]
      else $error("store did not write accumulator");
   a_store_cfg_kept: assert property ((store_s and !hits_cfg) |=> $stable(cfg_out)) // [RL3]
      else $error("store to the outside file altered config");

   a_cfg_load_copy: assert property (cfg_load_s // [RL4]
      |=> cfg_out == $past(acc_out) && $stable(zero_flag))
      else $error("config load wrong");
   a_cfg_load_acc_kept: assert property (cfg_load_s |=> $stable(acc_out)) // [RL4]
      else $error("config load altered accumulator");
   a_cfg_file_store: assert property ((store_s and hits_cfg) // [RL5]
      |-> !file_we ##1 cfg_out == $past(acc_out))
      else $error("store to config address missed");
   // a word must see the result of the one just before it
   a_chain_visible: assert property ((store_s and hits_cfg) ##1 (copy_to_acc_s and hits_cfg) // [RL6]
      |=> acc_out == $past(acc_out, 2))
      else $error("copy after store to config saw a stale value");

   a_idle_holds: assert property (idle_s // [RL6]
      |=> $stable(acc_out) && $stable(zero_flag) && $stable(cfg_out))
      else $error("idle changed state");
   a_idle_no_write: assert property (idle_s |-> !file_we) // [RL6]
      else $error("idle wrote the file");
   a_idle_handled: assert property (idle_s |-> instr_handled) // [RL6]
      else $error("idle not reported as handled");

   a_foreign_holds: assert property (foreign_s // [RL6]
      |=> $stable(acc_out) && $stable(zero_flag) && $stable(cfg_out))
      else $error("foreign opcode changed state");
   a_foreign_silent: assert property (foreign_s |-> !file_we && !instr_handled) // [RL6]
      else $error("foreign opcode wrote or was claimed");
   a_quiet_holds: assert property (quiet_s // [RL6]
      |=> $stable(acc_out) && $stable(zero_flag) && $stable(cfg_out))
      else $error("state changed with no instruction");
endmodule

// [tb/test_data_move_instruction_decode.sv]
`timescale 1ns/1ps
module test_data_move_instruction_decode;
   import dmid_pkg::*;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic instr_valid = 1'b0;
   logic [DMID_INSTR_W-1:0] instr = 14'h0000;
   logic [DMID_DATA_W-1:0] file_rdata = 8'h00;
   logic [DMID_ADDR_W-1:0] file_addr;
   logic file_we, zero_flag, instr_handled;
   logic [DMID_DATA_W-1:0] file_wdata, acc_out, cfg_out;
   int n_fail = 0;
   int checks = 0;
   int cycles = 0;
   dmid_core dut_u (.clk(clk), .arst_n(arst_n), .instr_valid(instr_valid), .instr(instr),
      .file_rdata(file_rdata), .file_addr(file_addr), .file_we(file_we), .file_wdata(file_wdata),
      .acc_out(acc_out), .zero_flag(zero_flag), .cfg_out(cfg_out), .instr_handled(instr_handled));
   initial begin
      forever #2.5 clk = ~clk;
   end
   task automatic close_out();
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // a hung run is cut short well past the few dozen cycles needed
   always @(posedge clk) begin
      cycles++;
      if (cycles == 500) begin
         n_fail++;
         close_out();
      end
   end
   task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // back to back: one word per cycle, comb outputs judged before the edge
   task automatic issue(logic [13:0] code, logic [7:0] rd, logic we, logic hd);
      @(negedge clk);
      instr_valid = 1'b1;
      instr = code;
      file_rdata = rd;
      #1;
      check("file_addr", {1'b0, file_addr}, {1'b0, code[6:0]});
      check("file_we", {7'h00, file_we}, {7'h00, we});
      check("instr_handled", {7'h00, instr_handled}, {7'h00, hd});
      @(posedge clk);
      #1;
   endtask
   task automatic regs(logic [7:0] acc, logic z, logic [7:0] cfg);
      check("acc_out", acc_out, acc);
      check("zero_flag", {7'h00, zero_flag}, {7'h00, z});
      check("cfg_out", cfg_out, cfg);
   endtask
   task automatic t_copy();
      issue(14'h0820, 8'h00, 1'b0, 1'b1);
      regs(8'h00, 1'b1, 8'hff);
      issue(14'h08a0, 8'h5a, 1'b0, 1'b1);
      regs(8'h00, 1'b0, 8'hff);
      issue(14'h087f, 8'h5a, 1'b0, 1'b1);
      regs(8'h5a, 1'b0, 8'hff);
      issue(14'h08a0, 8'h00, 1'b0, 1'b1);
      regs(8'h5a, 1'b1, 8'hff);
   endtask
   task automatic t_store();
      issue(14'h00a0, 8'h77, 1'b1, 1'b1);
      check("file_wdata", file_wdata, 8'h5a);
      regs(8'h5a, 1'b1, 8'hff);
   endtask
   task automatic t_cfg();
      issue(14'h0062, 8'h00, 1'b0, 1'b1);
      regs(8'h5a, 1'b1, 8'h5a);
      issue(14'h0820, 8'h33, 1'b0, 1'b1);
      regs(8'h33, 1'b0, 8'h5a);
      issue(14'h0081, 8'h00, 1'b0, 1'b1);
      regs(8'h33, 1'b0, 8'h33);
      issue(14'h0820, 8'h00, 1'b0, 1'b1);
      regs(8'h00, 1'b1, 8'h33);
      issue(14'h0801, 8'h00, 1'b0, 1'b1);
      regs(8'h33, 1'b0, 8'h33);
   endtask
   task automatic t_idle();
      issue(14'h0060, 8'h00, 1'b0, 1'b1);
      regs(8'h33, 1'b0, 8'h33);
      issue(14'h0000, 8'h00, 1'b0, 1'b1);
      regs(8'h33, 1'b0, 8'h33);
      issue(14'h3fff, 8'h00, 1'b0, 1'b0);
      regs(8'h33, 1'b0, 8'h33);
   endtask
   // back to back words see each other's results; the config address ignores file_rdata
   task automatic t_chain();
      issue(14'h0820, 8'hc3, 1'b0, 1'b1);
      regs(8'hc3, 1'b0, 8'h33);
      issue(14'h0081, 8'h00, 1'b0, 1'b1);
      regs(8'hc3, 1'b0, 8'hc3);
      issue(14'h0801, 8'h00, 1'b0, 1'b1);
      regs(8'hc3, 1'b0, 8'hc3);
      issue(14'h0820, 8'h00, 1'b0, 1'b1);
      regs(8'h00, 1'b1, 8'hc3);
      issue(14'h0062, 8'h00, 1'b0, 1'b1);
      regs(8'h00, 1'b1, 8'h00);
      issue(14'h0820, 8'h44, 1'b0, 1'b1);
      regs(8'h44, 1'b0, 8'h00);
      issue(14'h0881, 8'h44, 1'b0, 1'b1);
      regs(8'h44, 1'b1, 8'h00);
   endtask
   // reset in mid-run, then a word one cycle after release
   task automatic t_reset();
      @(negedge clk);
      instr_valid = 1'b0;
      arst_n = 1'b0;
      #1;
      regs(8'h00, 1'b0, 8'hff);
      @(negedge clk);
      arst_n = 1'b1;
      issue(14'h0062, 8'h00, 1'b0, 1'b1);
      regs(8'h00, 1'b0, 8'h00);
   endtask
   initial begin
      repeat (2) @(posedge clk);
      @(negedge clk);
      regs(8'h00, 1'b0, 8'hff);
      arst_n = 1'b1;
      t_copy();
      t_store();
      t_cfg();
      t_idle();
      t_chain();
      t_reset();
      @(negedge clk);
      instr_valid = 1'b0;
      close_out();
   end
endmodule
